// >>> src/i2cee_pkg.sv
// Shared constants and types for the serial EEPROM target logic
package i2cee_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned PAGE_W     = 6;
  localparam int unsigned DATA_W     = 8;
  localparam logic [7:0]  ERASED_VAL = 8'hFF;

  // ----------------------------------------------------------------
  // Target address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE    = 4'hA;
  localparam logic [1:0] DEV_ZEROS   = 2'h0;
  localparam int unsigned HI_ADDR_W  = ADDR_W - DATA_W;

  // ----------------------------------------------------------------
  // Bit counter positions within one byte frame
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST   = 4'h0;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_END     = 4'h9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_WR_NS       = 5000000;
  localparam int unsigned T_PU_NS       = 350000;
  localparam int unsigned WR_CYCLES_DEF = T_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned PU_CYCLES_DEF = T_PU_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } i2cee_state_type;

endpackage

// >>> src/i2cee_mem.sv
// Byte array with registered read data, erased at start
`timescale 1ns/1ns
module i2cee_mem #(
  parameter int unsigned ADDR_W = i2cee_pkg::ADDR_W,
  parameter int unsigned DATA_W = i2cee_pkg::DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  import i2cee_pkg::*;

  logic [DATA_W-1:0] mem_array [0:(1<<ADDR_W)-1];

  // ----------------------------------------------------------------
  // Delivery state: every byte erased
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem_array[i] = ERASED_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_array[addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_array[addr_i];
  end

endmodule // i2cee_mem

// >>> src/i2cee_top.sv
// Target-side I2C logic of a 32768-byte serial EEPROM
// Overview of operation
// - Send zero by pulling low, one releases
// - Sample on SCL rise, change after fall
// - SDA change with SCL high is condition
// - START is SDA fall, STOP rise, SCL high
// - Ignore everything not preceded by START
// - Match 1010, strap, 0, 0, then R/W
// - Strap floats low; A0/A1 or A8/A9
// - Ack address, address bytes, unprotected data
// - Write-protect high rejects all array writes
// - Read: release ninth clock, continue on ack
// - Byte write acked; write starts on STOP
// - No address ack during internal write
// - Fifteen address bits: page and byte
// - Page write wraps within 64-byte page
// - Read address: ack, send current byte
// - Selective read loads all fifteen bits
// - NoACK then STOP returns to standby
// - Sequential read wraps at memory end
// - Array erased to FFh at delivery
// - Ready after power-up delay from reset
`timescale 1ns/1ns
module i2cee_top #(
  parameter int unsigned WR_CYCLES = i2cee_pkg::WR_CYCLES_DEF,
  parameter int unsigned PU_CYCLES = i2cee_pkg::PU_CYCLES_DEF
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic scl_clk_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic wp_i,
  input  wire logic addr_strap_in_i,
  output logic      busy_o,
  output logic      ready_o
);
  import i2cee_pkg::*;

  localparam int unsigned WR_CW = $clog2(WR_CYCLES + 1);
  localparam int unsigned PU_CW = $clog2(PU_CYCLES + 1);

  // ----------------------------------------------------------------
  // Link domain: capture one data bit per SCL rise
  // ----------------------------------------------------------------
  logic bit_cap_reg = 1'b0;
  logic bit_tog_reg = 1'b0;

  always_ff @(posedge scl_clk_i) begin
    bit_cap_reg <= sda_i;
    bit_tog_reg <= ~bit_tog_reg;
  end

  // ----------------------------------------------------------------
  // Synchronisers into the reference domain
  // ----------------------------------------------------------------
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_s3_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_s3_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;

  always_ff @(posedge ref_clk_i) begin
    scl_s1_reg   <= scl_clk_i;
    scl_s2_reg   <= scl_s1_reg;
    scl_s3_reg   <= scl_s2_reg;
    sda_s1_reg   <= sda_i;
    sda_s2_reg   <= sda_s1_reg;
    sda_s3_reg   <= sda_s2_reg;
    tog_s1_reg   <= bit_tog_reg;
    tog_s2_reg   <= tog_s1_reg;
    tog_s3_reg   <= tog_s2_reg;
    wp_s1_reg    <= wp_i;
    wp_s2_reg    <= wp_s1_reg;
    strap_s1_reg <= addr_strap_in_i;
    strap_s2_reg <= strap_s1_reg;
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl_high;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  assign scl_high = scl_s2_reg & scl_s3_reg;
  assign start_ev = scl_high & sda_s3_reg & ~sda_s2_reg;
  assign stop_ev  = scl_high & ~sda_s3_reg & sda_s2_reg;
  // SCL rise crosses as a toggle; the captured bit holds until the next rise
  assign rise_ev  = tog_s2_reg ^ tog_s3_reg;
  assign fall_ev  = scl_s3_reg & ~scl_s2_reg;

  // ----------------------------------------------------------------
  // Power-up delay and internal write timer
  // ----------------------------------------------------------------
  logic [PU_CW-1:0] pu_cnt_reg;
  logic [WR_CW-1:0] wr_cnt_reg;
  logic             wrote_reg;
  logic             busy;
  logic             ready;

  assign busy  = (wr_cnt_reg != '0);
  assign ready = (pu_cnt_reg == '0);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pu_cnt_reg <= PU_CW'(PU_CYCLES);
    end else if (!ready) begin
      pu_cnt_reg <= pu_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_cnt_reg <= '0;
    end else if (stop_ev && wrote_reg) begin
      wr_cnt_reg <= WR_CW'(WR_CYCLES);
    end else if (busy) begin
      wr_cnt_reg <= wr_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  i2cee_state_type       state_reg;
  logic [3:0]            bit_cnt_reg;
  logic [DATA_W-1:0]     rx_reg;
  logic [DATA_W-1:0]     tx_reg;
  logic [HI_ADDR_W-1:0]  addr_hi_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic                  mack_reg;
  logic                  oe_reg;
  logic                  mem_we_reg;
  logic [DATA_W-1:0]     mem_wdata_reg;
  logic [DATA_W-1:0]     mem_rdata;
  logic [7:0]            dev_match;

  assign dev_match = {DEV_TYPE, strap_s2_reg, DEV_ZEROS, 1'b0};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= BIT_FIRST;
      rx_reg        <= '0;
      tx_reg        <= '0;
      addr_hi_reg   <= '0;
      addr_reg      <= '0;
      mack_reg      <= 1'b0;
      oe_reg        <= 1'b0;
    end else begin
      if (!ready) begin
        state_reg <= ST_IDLE;
        oe_reg    <= 1'b0;
      end else if (start_ev) begin
        state_reg   <= ST_DEV;
        bit_cnt_reg <= BIT_FIRST;
        oe_reg      <= 1'b0;
      end else if (stop_ev) begin
        state_reg <= ST_IDLE;
        oe_reg    <= 1'b0;
      end else if (state_reg == ST_IDLE || state_reg == ST_IGNORE) begin
        oe_reg <= 1'b0;
      end else if (rise_ev) begin
        if (bit_cnt_reg < BIT_ACK) begin
          rx_reg      <= {rx_reg[DATA_W-2:0], bit_cap_reg};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end else if (bit_cnt_reg == BIT_ACK) begin
          mack_reg    <= ~bit_cap_reg;
          bit_cnt_reg <= BIT_END;
        end
      end else if (fall_ev) begin
        if (bit_cnt_reg == BIT_ACK) begin
          case (state_reg)
            ST_DEV: begin
              if (rx_reg[7:1] == dev_match[7:1] && !busy) begin
                oe_reg <= 1'b1;
                tx_reg <= {7'h00, rx_reg[0]};
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
            ST_AHI: begin
              oe_reg      <= 1'b1;
              addr_hi_reg <= rx_reg[HI_ADDR_W-1:0];
            end
            ST_ALO: begin
              oe_reg   <= 1'b1;
              addr_reg <= {addr_hi_reg, rx_reg};
            end
            ST_WDATA: begin
              if (!wp_s2_reg) begin
                oe_reg <= 1'b1;
              end
            end
            ST_RDATA: begin
              oe_reg <= 1'b0;
            end
            default: begin
              oe_reg <= 1'b0;
            end
          endcase
        end else if (bit_cnt_reg == BIT_END) begin
          bit_cnt_reg <= BIT_FIRST;
          oe_reg      <= 1'b0;
          case (state_reg)
            ST_DEV: begin
              if (tx_reg[0]) begin
                state_reg <= ST_RDATA;
                tx_reg    <= mem_rdata;
                oe_reg    <= ~mem_rdata[DATA_W-1];
                addr_reg  <= addr_reg + 1'b1;
              end else begin
                state_reg <= ST_AHI;
              end
            end
            ST_AHI: begin
              state_reg <= ST_ALO;
            end
            ST_ALO: begin
              state_reg <= ST_WDATA;
            end
            ST_WDATA: begin
              if (mem_we_reg || oe_reg) begin
                addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 1'b1;
              end
            end
            ST_RDATA: begin
              if (mack_reg) begin
                tx_reg   <= mem_rdata;
                oe_reg   <= ~mem_rdata[DATA_W-1];
                addr_reg <= addr_reg + 1'b1;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
            default: begin
              state_reg <= ST_IGNORE;
            end
          endcase
        end else if (state_reg == ST_RDATA) begin
          tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
          oe_reg <= ~tx_reg[DATA_W-2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Array write port: one pulse per acknowledged data byte
  // ----------------------------------------------------------------
  logic wdata_ack;

  // Same priority as the protocol engine: reset, START, STOP, then bit edges
  assign wdata_ack = ready && !start_ev && !stop_ev && !rise_ev && fall_ev &&
                     bit_cnt_reg == BIT_ACK && state_reg == ST_WDATA && !wp_s2_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= '0;
    end else begin
      mem_we_reg <= wdata_ack;
      if (wdata_ack) begin
        mem_wdata_reg <= rx_reg;
      end
    end
  end

  // Remembers that the next STOP must start the internal write cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wrote_reg <= 1'b0;
    end else if (ready && stop_ev) begin
      wrote_reg <= 1'b0;
    end else if (wdata_ack) begin
      wrote_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  i2cee_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .clk_i     (ref_clk_i),
    .wr_en_i   (mem_we_reg),
    .addr_i    (addr_reg),
    .wr_data_i (mem_wdata_reg),
    .rd_data_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Registered outputs; SDA is open drain, only ever pulled low
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sda_oe_o <= 1'b0;
    end else begin
      sda_oe_o <= oe_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= busy;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= ready;
    end
  end

endmodule // i2cee_top

// >>> verification/i2cee_ctl.sv
// Bus controller model: makes SCL, START, STOP and SDA bits
`timescale 1ns/1ns
module i2cee_ctl (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  localparam int H = 300;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bit_x(input logic d, output logic s);
    #(H) sda_low_o = ~d;
    #(H) scl_o = 1'b1;
    s = sda_i;
    #(H) scl_o = 1'b0;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b1;
    #(H) scl_o = 1'b0;
  endtask
  task automatic stop();
    #(H) sda_low_o = 1'b1;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b0;
    #(H);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    bit_x(~ack, s);
  endtask
endmodule // i2cee_ctl

// >>> verification/i2cee_top_assertions.sv
// Port assertions of the EEPROM target
`timescale 1ns/1ns
module i2cee_chk #(
  parameter int unsigned WR_CYCLES = 200,
  parameter int unsigned PU_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic wp_i,
  input wire logic addr_strap_in_i,
  input wire logic busy_o,
  input wire logic ready_o
);
  int pu_cnt;
  int wr_cnt;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || pu_cnt > 90000) begin
      pu_cnt <= 0;
    end else begin
      pu_cnt <= pu_cnt + 1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    wr_cnt <= (busy_o && !rst_i) ? wr_cnt + 1 : 0;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_quiet: assert property ($fell(rst_i) |-> !sda_oe_o && !busy_o && !ready_o) else $error("outputs after reset");
  a_not_ready: assert property (!ready_o |-> !sda_oe_o) else $error("drive before ready");
  a_busy_quiet: assert property (busy_o |-> !sda_oe_o) else $error("ack while busy");
  a_drive_low: assert property (sda_oe_o |-> !sda_o) else $error("sda driven high");
  a_change_low: assert property ($changed(sda_oe_o) |-> !scl_clk_i && !$past(scl_clk_i, 3)) else $error("sda moved");
  a_stable_high: assert property ($rose(scl_clk_i) |=> $stable(sda_oe_o) [*8]) else $error("sda moved, scl high");
  a_busy_stop: assert property ($rose(busy_o) |-> scl_clk_i && sda_i && $past(scl_clk_i, 8)) else $error("busy without stop");
  a_busy_len: assert property ($fell(busy_o) |-> wr_cnt >= WR_CYCLES - 1 && wr_cnt <= WR_CYCLES + 2) else $error("busy len");
  a_ready_time: assert property ($rose(ready_o) |-> pu_cnt >= PU_CYCLES - 1 && pu_cnt <= PU_CYCLES + 3) else $error("ready time");
  a_ready_holds: assert property (ready_o |=> ready_o) else $error("ready dropped");
endmodule // i2cee_chk

bind i2cee_top i2cee_chk #(.WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES)) i2cee_chk_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .wp_i(wp_i), .addr_strap_in_i(addr_strap_in_i), .busy_o(busy_o), .ready_o(ready_o));

// >>> verification/test_i2c_serial_eeprom_slave.sv
// Self-checking bench for the EEPROM target
`timescale 1ns/1ns
module test_i2c_serial_eeprom_slave;
  logic clk, rst, wp, strap, scl, low, sda_w, sda_o, sda_oe, busy, ready, k;
  int n_mismatch = 0;
  int n_tests = 0;
  assign sda_w = ~low & (sda_oe ? sda_o : 1'b1);
  i2cee_top #(.WR_CYCLES(2000), .PU_CYCLES(20)) i2cee_top_i (
    .ref_clk_i(clk), .rst_i(rst), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .wp_i(wp), .addr_strap_in_i(strap), .busy_o(busy), .ready_o(ready));
  i2cee_ctl i2cee_ctl_i (.sda_i(sda_w), .scl_o(scl), .sda_low_o(low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    i2cee_ctl_i.wbyte(b, k);
    chk({7'h00, k}, {7'h00, exp});
  endtask
  task automatic addr(input logic [14:0] a);
    i2cee_ctl_i.start();
    send(8'hA0, 1'b1);
    send({1'b0, a[14:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d;
    addr(a);
    i2cee_ctl_i.start();
    send(8'hA1, 1'b1);
    i2cee_ctl_i.rbyte(1'b1, d);
    chk(d, e0);
    i2cee_ctl_i.rbyte(1'b0, d);
    chk(d, e1);
    i2cee_ctl_i.stop();
  endtask
  // Write n bytes, then poll the target address until acknowledged
  task automatic wr(input logic [14:0] a, input logic [23:0] d, input int n, input logic dack);
    int polls;
    addr(a);
    for (int i = 0; i < n; i++) begin
      send(d[23-8*i -: 8], dack);
    end
    i2cee_ctl_i.stop();
    repeat (4) @(negedge clk);
    chk({7'h00, busy}, {7'h00, dack});
    polls = 0;
    k = 1'b0;
    while (dack && !k) begin
      if (polls == 8) begin
        n_mismatch++;
        results();
      end
      i2cee_ctl_i.start();
      i2cee_ctl_i.wbyte(polls == 0 ? 8'hA1 : 8'hA0, k);
      i2cee_ctl_i.stop();
      polls++;
    end
    if (dack) chk({7'h00, polls > 1}, 8'h01);
  endtask
  task automatic t_rw();
    rd(15'h1234, 8'hFF, 8'hFF);
    wr(15'h0000, 24'h3C0000, 1, 1'b1);
    rd(15'h7FFF, 8'hFF, 8'h3C);
    $display("read write test done");
  endtask
  task automatic t_page();
    wr(15'h007E, 24'hA55AC3, 3, 1'b1);
    rd(15'h007F, 8'h5A, 8'hFF);
    rd(15'h0040, 8'hC3, 8'hFF);
    $display("page test done");
  endtask
  // Leave the counter at 0x0040, then read from it without an address word
  task automatic t_now();
    logic [7:0] d;
    rd(15'h003E, 8'hFF, 8'hFF);
    i2cee_ctl_i.start();
    send(8'hA1, 1'b1);
    i2cee_ctl_i.rbyte(1'b0, d);
    chk(d, 8'hC3);
    i2cee_ctl_i.stop();
    $display("immediate read test done");
  endtask
  task automatic t_wp();
    @(negedge clk) wp = 1'b1;
    wr(15'h0001, 24'h770000, 1, 1'b0);
    @(negedge clk) wp = 1'b0;
    rd(15'h0001, 8'hFF, 8'hFF);
    $display("protect test done");
  endtask
  task automatic t_strap();
    @(negedge clk) strap = 1'b1;
    i2cee_ctl_i.start();
    send(8'hA0, 1'b0);
    send(8'h00, 1'b0);
    i2cee_ctl_i.start();
    send(8'hA8, 1'b1);
    i2cee_ctl_i.stop();
    @(negedge clk) strap = 1'b0;
    $display("strap test done");
  endtask
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    strap = 1'b0;
    repeat (8) @(negedge clk);
    chk({5'h00, sda_oe, busy, ready}, 8'h00);
    rst = 1'b0;
    for (int i = 0; i < 200 && ready !== 1'b1; i++) @(negedge clk);
    chk({7'h00, ready}, 8'h01);
    if (ready !== 1'b1) results();
    t_rw();
    t_page();
    t_now();
    t_wp();
    t_strap();
    results();
  end
endmodule // test_i2c_serial_eeprom_slave
